/* include/sleep_seq_pkg.sv */
/*
  Shared constants, types and register layout for the power-down, wake-up
  and reset sequencer with its real time clock divider.
  Assumes a single 10 MHz clock that keeps running during power-down.
*/
`default_nettype none

package sleep_seq_pkg;

  localparam int CLK_PERIOD_NS = 100;

  // register addresses on the core's data-memory bus
  localparam logic [7:0] RATE_CTL_ADDR = 8'h09;
  localparam logic [7:0] INT_HI_ADDR = 8'h1e;

  // rtc_rate_and_osc_control layout
  localparam logic [7:0] RATE_CTL_RESET = 8'h07;
  localparam logic [7:0] RATE_CTL_RW_MASK = 8'h17;
  localparam int RATE_LSB = 0;
  localparam int RATE_W = 3;
  localparam int FAST_START_BIT = 4;

  // interrupt_control_high layout
  localparam logic [7:0] INT_HI_RESET = 8'h00;
  localparam logic [7:0] INT_HI_RW_MASK = 8'h77;
  localparam int RTC_FLAG_BIT = 6;
  localparam int RTC_EN_BIT = 2;

  // rtc divider
  localparam int RTC_DIV_W = 15;
  localparam logic [RTC_DIV_W-1:0] RTC_FULL_MASK = 15'h7fff;
  localparam logic [2:0] RTC_MAX_CODE = 3'h7;

  // reset values handed to the core
  localparam logic [11:0] RTC_VECTOR = 12'h018;
  localparam logic [11:0] RESET_PROG_ADDR = 12'h000;
  localparam logic [7:0] PORT_RESET = 8'hff;

  // start-up delay, in system clock periods
  localparam int STARTUP_CYCLES = 1024;
  localparam int STARTUP_W = 11;

  localparam int IRQ_SRC = 6;

  typedef enum logic [1:0] {
    SEQ_INIT,
    SEQ_STARTUP,
    SEQ_RUN,
    SEQ_SLEEP
  } seq_state_t;

  typedef struct packed {
    logic expiry;
    logic entered;
  } sleep_flags_t;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } reg_req_t;

endpackage

`default_nettype wire

/* verilog/startup_delay_counter.sv */
/*
  Start-up delay counter: counts enabled clock cycles after a start pulse
  and pulses done once the programmed number has passed.
  Assumes start and count_en come from logic on the same clock.
*/
`default_nettype none

module startup_delay_counter #(
  parameter int CYCLES = sleep_seq_pkg::STARTUP_CYCLES,
  parameter int W = sleep_seq_pkg::STARTUP_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic start,
  input wire logic count_en,
  // status
  output logic busy_ff,
  output logic done_ff
);

  localparam logic [W-1:0] LAST = W'(CYCLES - 1);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  logic nxt_busy;
  logic nxt_done;

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_busy = busy_ff;
    nxt_done = 1'b0;
    if (start) begin
      nxt_cnt = '0;
      nxt_busy = 1'b1;
    end else if (busy_ff && count_en) begin
      // only oscillator-running cycles count towards stability
      if (cnt_ff == LAST) begin
        nxt_busy = 1'b0;
        nxt_done = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
    end
  end

endmodule

`default_nettype wire

/* verilog/sleep_wake_sequencer.sv */
/*
  Power-down, wake-up and reset sequencer with the real time clock
  time-out divider and its two registers on the core's data bus.
  Assumes clk keeps running while the system oscillator is reported off;
  the core, watchdog and other interrupt sources sit on clk as well.
*/
// Contract
// [RULE1] rate field picks divide 2^8 to 2^15
// [RULE2] software avoids the four shortest rate codes
// [RULE3] each time-out sets the rtc request flag
// [RULE4] enabled time-out calls address 18H
// [RULE5] time-out pulse clocks timer counter zero
// [RULE6] bit 4 selects quick or slow start
// [RULE7] bit 3 undefined, bits 5-7 read zero
// [RULE8] power-down stops oscillator, holds all state
// [RULE9] power-down clears and restarts the watchdog; the code clears it only when watchdog_on_slow_osc is set
// [RULE10] power-down sets sleep flag, clears expiry
// [RULE11] lcd keeps running on slow oscillators
// [RULE12] reset, interrupt, port or watchdog wake
// [RULE13] sleep flag cleared by power-up, watchdog clear
// [RULE14] watchdog in sleep sets expiry, warm reset
// [RULE15] per-bit port wake, resume next instruction
// [RULE16] disabled or stack-full interrupt resumes next
// [RULE17] flag already set cannot wake
// [RULE18] dummy period before resuming execution
// [RULE19] 1024 cycle start-up after power-up, wake
// [RULE20] flag pair encodes the reset cause
// [RULE21] chip reset zeroes program counter, masks interrupts
// [RULE22] full resets load ports and registers
// [RULE23] watchdog overflow when running: full reset
// [RULE24] rtc divider runs through power-down
// [RULE25] start-up counts only with oscillator running
`default_nettype none

module sleep_wake_sequencer #(
  parameter int STARTUP_CYCLES = sleep_seq_pkg::STARTUP_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register access from the core
  input wire sleep_seq_pkg::reg_req_t reg_req,
  output logic [7:0] reg_rdata_ff,
  // instructions and core state
  input wire logic halt_instr,
  input wire logic watchdog_clear_instruction,
  input wire logic master_int_enable,
  input wire logic stack_full,
  input wire logic rtc_call_ack,
  input wire logic [4:0] other_irq_flags,
  input wire logic [4:0] other_irq_enables,
  // watchdog and clock source options
  input wire logic watchdog_overflow,
  input wire logic watchdog_on_slow_osc,
  input wire logic lcd_on_slow_osc,
  // pins
  input wire logic external_init_pin_n,
  input wire logic rtc_osc_pin,
  input wire logic [7:0] port_a,
  input wire logic [7:0] port_a_wake_option,
  // status flags
  output sleep_seq_pkg::sleep_flags_t flags_ff,
  // sequencing outputs
  output logic cpu_run_ff,
  output logic sys_osc_run_ff,
  output logic lcd_run_ff,
  output logic chip_reset_ff,
  output logic warm_reset_ff,
  output logic watchdog_clear_ff,
  output logic resume_ff,
  output logic resume_to_int_ff,
  // rtc outputs
  output logic rtc_call_req_ff,
  output logic [11:0] rtc_call_vector_ff,
  output logic timer_event_counter_zero_clk_ff,
  output logic slow_crystal_fast_start
);

  // pin synchronisers; the third stage only feeds edge detection
  logic [7:0] pin_a_s1_ff, pin_a_s2_ff, pin_a_s3_ff;
  logic init_s1_ff, init_s2_ff;
  logic rtc_s1_ff, rtc_s2_ff, rtc_s3_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_a_s1_ff <= 8'hff;
      pin_a_s2_ff <= 8'hff;
      pin_a_s3_ff <= 8'hff;
      init_s1_ff <= 1'b1;
      init_s2_ff <= 1'b1;
      rtc_s1_ff <= 1'b0;
      rtc_s2_ff <= 1'b0;
      rtc_s3_ff <= 1'b0;
    end else begin
      pin_a_s1_ff <= port_a;
      pin_a_s2_ff <= pin_a_s1_ff;
      pin_a_s3_ff <= pin_a_s2_ff;
      init_s1_ff <= external_init_pin_n;
      init_s2_ff <= init_s1_ff;
      rtc_s1_ff <= rtc_osc_pin;
      rtc_s2_ff <= rtc_s1_ff;
      rtc_s3_ff <= rtc_s2_ff;
    end
  end

  logic rtc_tick;
  logic [7:0] port_fall;
  logic pin_low;
  assign rtc_tick = rtc_s2_ff & ~rtc_s3_ff;
  assign port_fall = pin_a_s3_ff & ~pin_a_s2_ff & port_a_wake_option; // RULE15
  assign pin_low = ~init_s2_ff;

  // sequencer state
  sleep_seq_pkg::seq_state_t state_ff, nxt_state;
  sleep_seq_pkg::sleep_flags_t nxt_flags;
  logic [sleep_seq_pkg::IRQ_SRC-1:0] stale_ff, nxt_stale;
  logic int_wake_ff, nxt_int_wake;
  logic nxt_chip_reset, nxt_warm_reset, nxt_wd_clear, nxt_resume, nxt_resume_int;
  logic su_start, su_busy, su_done;

  logic [7:0] rate_ctl_ff, nxt_rate_ctl;
  logic [7:0] int_hi_ff, nxt_int_hi;
  logic [sleep_seq_pkg::RTC_DIV_W-1:0] rtc_cnt_ff, nxt_rtc_cnt;
  logic rtc_timeout;

  logic [sleep_seq_pkg::IRQ_SRC-1:0] irq_flags, irq_en, new_irq;
  assign irq_flags = {int_hi_ff[sleep_seq_pkg::RTC_FLAG_BIT], other_irq_flags};
  assign irq_en = {int_hi_ff[sleep_seq_pkg::RTC_EN_BIT], other_irq_enables};
  assign new_irq = irq_flags & ~stale_ff; // RULE17

  always_comb begin
    nxt_state = state_ff;
    nxt_flags = flags_ff;
    nxt_stale = stale_ff;
    nxt_int_wake = int_wake_ff;
    nxt_chip_reset = 1'b0;
    nxt_warm_reset = 1'b0;
    nxt_wd_clear = 1'b0;
    nxt_resume = 1'b0;
    nxt_resume_int = 1'b0;
    su_start = 1'b0;
    if (pin_low) begin
      // held in full initialisation while the pin is low
      nxt_state = sleep_seq_pkg::SEQ_INIT; // RULE12
      nxt_chip_reset = 1'b1; // RULE21
      if (state_ff == sleep_seq_pkg::SEQ_SLEEP) begin
        nxt_flags = '{expiry: 1'b0, entered: 1'b1}; // RULE20
      end
    end else begin
      case (state_ff)
        sleep_seq_pkg::SEQ_INIT: begin
          nxt_state = sleep_seq_pkg::SEQ_STARTUP;
          su_start = 1'b1; // RULE19
          nxt_int_wake = 1'b0;
        end
        sleep_seq_pkg::SEQ_STARTUP: begin
          if (su_done) begin
            // dummy period over: hand control back
            nxt_state = sleep_seq_pkg::SEQ_RUN; // RULE18
            nxt_resume = 1'b1;
            nxt_resume_int = int_wake_ff; // RULE16
          end
        end
        sleep_seq_pkg::SEQ_RUN: begin
          if (watchdog_overflow) begin
            nxt_chip_reset = 1'b1; // RULE23
            nxt_flags.expiry = 1'b1; // RULE20
          end else if (halt_instr) begin
            nxt_state = sleep_seq_pkg::SEQ_SLEEP; // RULE8
            nxt_flags = '{expiry: 1'b0, entered: 1'b1}; // RULE10
            nxt_wd_clear = watchdog_on_slow_osc; // RULE9
            nxt_stale = irq_flags; // RULE17
          end else if (watchdog_clear_instruction) begin
            nxt_flags.entered = 1'b0; // RULE13
          end
        end
        sleep_seq_pkg::SEQ_SLEEP: begin
          // a watchdog on the instruction clock is stopped here
          if (watchdog_overflow && watchdog_on_slow_osc) begin
            nxt_state = sleep_seq_pkg::SEQ_STARTUP; // RULE14
            nxt_flags = '{expiry: 1'b1, entered: 1'b1}; // RULE14
            nxt_warm_reset = 1'b1; // RULE14
            nxt_int_wake = 1'b0;
            su_start = 1'b1;
          end else if (|new_irq || |port_fall) begin
            nxt_state = sleep_seq_pkg::SEQ_STARTUP; // RULE12
            nxt_int_wake = |(new_irq & irq_en) & master_int_enable & ~stack_full; // RULE16
            su_start = 1'b1; // RULE19
          end
        end
        default: begin
          nxt_state = sleep_seq_pkg::SEQ_INIT;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= sleep_seq_pkg::SEQ_INIT;
      flags_ff <= '0; // RULE13
      stale_ff <= '0;
      int_wake_ff <= 1'b0;
      chip_reset_ff <= 1'b1;
      warm_reset_ff <= 1'b0;
      watchdog_clear_ff <= 1'b0;
      resume_ff <= 1'b0;
      resume_to_int_ff <= 1'b0;
      cpu_run_ff <= 1'b0;
      sys_osc_run_ff <= 1'b1;
      lcd_run_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      flags_ff <= nxt_flags;
      stale_ff <= nxt_stale;
      int_wake_ff <= nxt_int_wake;
      chip_reset_ff <= nxt_chip_reset;
      warm_reset_ff <= nxt_warm_reset;
      watchdog_clear_ff <= nxt_wd_clear;
      resume_ff <= nxt_resume;
      resume_to_int_ff <= nxt_resume_int;
      cpu_run_ff <= (nxt_state == sleep_seq_pkg::SEQ_RUN);
      sys_osc_run_ff <= (nxt_state != sleep_seq_pkg::SEQ_SLEEP); // RULE8
      lcd_run_ff <= (nxt_state != sleep_seq_pkg::SEQ_SLEEP) | lcd_on_slow_osc; // RULE11
    end
  end

  startup_delay_counter #(
    .CYCLES(STARTUP_CYCLES),
    .W(sleep_seq_pkg::STARTUP_W)
  ) u_startup (
    .clk(clk),
    .rst_n(rst_n),
    .start(su_start),
    .count_en(sys_osc_run_ff), // RULE25
    .busy_ff(su_busy),
    .done_ff(su_done)
  );

  // rtc divider and registers
  logic [sleep_seq_pkg::RTC_DIV_W-1:0] rate_mask;
  logic [2:0] rate_sel;
  logic full_init;
  assign rate_sel = rate_ctl_ff[sleep_seq_pkg::RATE_LSB +: sleep_seq_pkg::RATE_W];
  assign rate_mask = sleep_seq_pkg::RTC_FULL_MASK >> (sleep_seq_pkg::RTC_MAX_CODE - rate_sel); // RULE1
  assign rtc_timeout = rtc_tick && ((rtc_cnt_ff & rate_mask) == rate_mask); // RULE1
  assign full_init = chip_reset_ff; // RULE22

  always_comb begin
    nxt_rate_ctl = rate_ctl_ff;
    nxt_int_hi = int_hi_ff;
    nxt_rtc_cnt = rtc_cnt_ff;
    if (full_init) begin
      nxt_rate_ctl = sleep_seq_pkg::RATE_CTL_RESET; // RULE22
      nxt_int_hi = sleep_seq_pkg::INT_HI_RESET; // RULE22
      nxt_rtc_cnt = '0; // RULE21
    end else begin
      // the divider never looks at the sleep state
      if (rtc_tick) begin
        nxt_rtc_cnt = rtc_cnt_ff + 1'b1; // RULE24
      end
      if (reg_req.wr && reg_req.addr == sleep_seq_pkg::RATE_CTL_ADDR) begin
        nxt_rate_ctl = reg_req.wdata & sleep_seq_pkg::RATE_CTL_RW_MASK; // RULE6
      end
      if (reg_req.wr && reg_req.addr == sleep_seq_pkg::INT_HI_ADDR) begin
        nxt_int_hi = reg_req.wdata & sleep_seq_pkg::INT_HI_RW_MASK;
      end
      if (rtc_call_ack) begin
        nxt_int_hi[sleep_seq_pkg::RTC_FLAG_BIT] = 1'b0;
      end
      // a time-out in the same cycle as a clear is kept
      if (rtc_timeout) begin
        nxt_int_hi[sleep_seq_pkg::RTC_FLAG_BIT] = 1'b1; // RULE3
      end
    end
  end

  logic [7:0] nxt_rdata;
  always_comb begin
    nxt_rdata = 8'h00;
    if (reg_req.rd && reg_req.addr == sleep_seq_pkg::RATE_CTL_ADDR) begin
      nxt_rdata = rate_ctl_ff & sleep_seq_pkg::RATE_CTL_RW_MASK; // RULE7
    end else if (reg_req.rd && reg_req.addr == sleep_seq_pkg::INT_HI_ADDR) begin
      nxt_rdata = int_hi_ff & sleep_seq_pkg::INT_HI_RW_MASK;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rate_ctl_ff <= sleep_seq_pkg::RATE_CTL_RESET;
      int_hi_ff <= sleep_seq_pkg::INT_HI_RESET;
      rtc_cnt_ff <= '0;
      reg_rdata_ff <= 8'h00;
      rtc_call_req_ff <= 1'b0;
      rtc_call_vector_ff <= sleep_seq_pkg::RTC_VECTOR;
      timer_event_counter_zero_clk_ff <= 1'b0;
    end else begin
      rate_ctl_ff <= nxt_rate_ctl;
      int_hi_ff <= nxt_int_hi;
      rtc_cnt_ff <= nxt_rtc_cnt;
      reg_rdata_ff <= nxt_rdata;
      rtc_call_req_ff <= nxt_int_hi[sleep_seq_pkg::RTC_FLAG_BIT] & ~rtc_call_ack
        & nxt_int_hi[sleep_seq_pkg::RTC_EN_BIT] & master_int_enable & ~stack_full
        & (nxt_state == sleep_seq_pkg::SEQ_RUN); // RULE4
      rtc_call_vector_ff <= sleep_seq_pkg::RTC_VECTOR; // RULE4
      timer_event_counter_zero_clk_ff <= rtc_timeout; // RULE5
    end
  end

  assign slow_crystal_fast_start = rate_ctl_ff[sleep_seq_pkg::FAST_START_BIT]; // RULE6

  // checks
  logic [11:0] su_stay;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      su_stay <= '0;
    end else if (state_ff == sleep_seq_pkg::SEQ_STARTUP) begin
      su_stay <= su_stay + 1'b1;
    end else begin
      su_stay <= '0;
    end
  end

  sequence s_enter_sleep;
    state_ff == sleep_seq_pkg::SEQ_RUN && halt_instr && !watchdog_overflow && !pin_low;
  endsequence

  sequence s_slept;
    state_ff == sleep_seq_pkg::SEQ_SLEEP && !sys_osc_run_ff;
  endsequence

  property p_sleep_flags;
    @(posedge clk) disable iff (!rst_n)
    s_enter_sleep |=> flags_ff.entered && !flags_ff.expiry;
  endproperty
  a_sleep_flags: assert property (p_sleep_flags) else $error("sleep flags wrong"); // RULE10

  property p_osc_stop;
    @(posedge clk) disable iff (!rst_n)
    s_enter_sleep |=> s_slept ##0 !cpu_run_ff;
  endproperty
  a_osc_stop: assert property (p_osc_stop) else $error("oscillator not stopped"); // RULE8

  property p_wd_clear;
    @(posedge clk) disable iff (!rst_n)
    s_enter_sleep ##0 watchdog_on_slow_osc |=> watchdog_clear_ff ##1 !watchdog_clear_ff;
  endproperty
  a_wd_clear: assert property (p_wd_clear) else $error("watchdog not cleared"); // RULE9

  property p_rtc_flag;
    @(posedge clk) disable iff (!rst_n)
    rtc_timeout && !full_init |=> int_hi_ff[sleep_seq_pkg::RTC_FLAG_BIT];
  endproperty
  a_rtc_flag: assert property (p_rtc_flag) else $error("rtc flag not set"); // RULE3

  property p_startup_len;
    @(posedge clk) disable iff (!rst_n)
    $rose(cpu_run_ff) |-> $past(su_stay) >= 12'(STARTUP_CYCLES);
  endproperty
  a_startup_len: assert property (p_startup_len) else $error("start-up too short"); // RULE19

  property p_wd_warm;
    @(posedge clk) disable iff (!rst_n)
    state_ff == sleep_seq_pkg::SEQ_SLEEP && watchdog_overflow && watchdog_on_slow_osc
      && !pin_low |=> warm_reset_ff && !chip_reset_ff && flags_ff == 2'b11;
  endproperty
  a_wd_warm: assert property (p_wd_warm) else $error("warm reset wrong"); // RULE14

  property p_wd_run;
    @(posedge clk) disable iff (!rst_n)
    state_ff == sleep_seq_pkg::SEQ_RUN && watchdog_overflow && !pin_low
      |=> chip_reset_ff && flags_ff.expiry ##1 rate_ctl_ff == sleep_seq_pkg::RATE_CTL_RESET;
  endproperty
  a_wd_run: assert property (p_wd_run) else $error("watchdog full reset wrong"); // RULE23

  property p_sleep_flag_clear;
    @(posedge clk) disable iff (!rst_n)
    state_ff == sleep_seq_pkg::SEQ_RUN && watchdog_clear_instruction && !halt_instr
      && !watchdog_overflow && !pin_low |=> !flags_ff.entered;
  endproperty
  a_sleep_flag_clear: assert property (p_sleep_flag_clear) else $error("sleep flag not cleared"); // RULE13

  property p_rate_read;
    @(posedge clk) disable iff (!rst_n)
    reg_req.rd && reg_req.addr == sleep_seq_pkg::RATE_CTL_ADDR |=> reg_rdata_ff[7:5] == 3'h0
      && !reg_rdata_ff[3];
  endproperty
  a_rate_read: assert property (p_rate_read) else $error("reserved bits set"); // RULE7

endmodule

`default_nettype wire

/* dv/core_side_model.sv */
/*
  Far-side model: a free-running slow oscillator and the core's acceptance
  of the rtc subroutine call.
  Assumes the sequencer's clk and an active-low asynchronous reset.
*/
`default_nettype none

module core_side_model #(
  parameter int HALF_NS = 100
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // core side
  input wire logic rtc_call_req,
  input wire logic cpu_run,
  input wire logic [2:0] ack_wait,
  output logic rtc_call_ack,
  // slow oscillator
  output logic rtc_osc_pin
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [2:0] wait_ff;

  // runs far faster than a real crystal so that long periods fit the run
  initial begin
    rtc_osc_pin = 1'b0;
    #37;
    forever #HALF_NS rtc_osc_pin = ~rtc_osc_pin;
  end

  // the core only takes a call while it executes; ack_wait makes it slow
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_ff <= 3'h0;
      rtc_call_ack <= 1'b0;
    end else begin
      rtc_call_ack <= 1'b0;
      if (rtc_call_req && cpu_run && !rtc_call_ack) begin
        if (wait_ff >= ack_wait) begin
          rtc_call_ack <= 1'b1;
          wait_ff <= 3'h0;
        end else begin
          wait_ff <= wait_ff + 3'h1;
        end
      end else begin
        wait_ff <= 3'h0;
      end
    end
  end
endmodule

`default_nettype wire

/* dv/rtc_halt_wakeup_reset_tb_top.sv */
/*
  Self-checking bench for the power-down, wake-up and reset sequencer.
  Assumes a shortened start-up count and a sped-up slow oscillator.
*/
`default_nettype none

module rtc_halt_wakeup_reset_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int ST = 16;
  localparam int LIMIT = 80000;
  logic clk, rst_n, halt_instr, wclr, mie, stack_full, ack, ovf, wd_slow, lcd_slow;
  logic pin_n, osc, cpu_run_ff, osc_run_ff, lcd_run_ff, chip_rst_ff, warm_ff, wclr_ff;
  logic resume_ff, rint_ff, req_ff, tmr_ff, fast_start;
  logic [7:0] rdata, port_a, wake_opt, d, v;
  logic [4:0] irq_f, irq_e;
  logic [2:0] ack_wait;
  logic [11:0] vec_ff;
  sleep_seq_pkg::reg_req_t reg_req;
  sleep_seq_pkg::sleep_flags_t flags_ff;
  int miscompares, checks, seed, cyc, n;

  sleep_wake_sequencer #(.STARTUP_CYCLES(ST)) sleep_wake_sequencer_inst (
    .clk(clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata_ff(rdata),
    .halt_instr(halt_instr), .watchdog_clear_instruction(wclr),
    .master_int_enable(mie), .stack_full(stack_full), .rtc_call_ack(ack),
    .other_irq_flags(irq_f), .other_irq_enables(irq_e), .watchdog_overflow(ovf),
    .watchdog_on_slow_osc(wd_slow), .lcd_on_slow_osc(lcd_slow),
    .external_init_pin_n(pin_n), .rtc_osc_pin(osc), .port_a(port_a),
    .port_a_wake_option(wake_opt), .flags_ff(flags_ff), .cpu_run_ff(cpu_run_ff),
    .sys_osc_run_ff(osc_run_ff), .lcd_run_ff(lcd_run_ff), .chip_reset_ff(chip_rst_ff),
    .warm_reset_ff(warm_ff), .watchdog_clear_ff(wclr_ff), .resume_ff(resume_ff),
    .resume_to_int_ff(rint_ff), .rtc_call_req_ff(req_ff),
    .rtc_call_vector_ff(vec_ff), .timer_event_counter_zero_clk_ff(tmr_ff),
    .slow_crystal_fast_start(fast_start));

  core_side_model core_side_model_inst (
    .clk(clk), .rst_n(rst_n), .rtc_call_req(req_ff), .cpu_run(cpu_run_ff),
    .ack_wait(ack_wait), .rtc_call_ack(ack), .rtc_osc_pin(osc));

  initial clk = 1'b0;
  always #50 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      miscompares++;
      $display("[ERR] %0t run limit reached", $time);
      results();
    end
  end

  task automatic results();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp, input string m);
    chk({15'h0, got}, {15'h0, exp}, m);
  endtask

  task automatic chkn(input int got, input int lo, input int hi, input string m);
    checks++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("[ERR] %0t %s count %0d", $time, m, got);
    end
  endtask

  // cycles between time-outs: 2 clk per oscillator tick
  function automatic int gap(input int code);
    return (1 << (8 + code)) * 2;
  endfunction

  function automatic logic sig(input int k);
    case (k)
      0: return cpu_run_ff;
      1: return tmr_ff;
      2: return req_ff;
      3: return resume_ff;
      default: return !req_ff;
    endcase
  endfunction

  task automatic wt(input int k, input int lim, output int c);
    c = 0;
    do begin
      @(posedge clk);
      #1 c++;
    end while (sig(k) !== 1'b1 && c < lim);
    if (sig(k) !== 1'b1) begin
      miscompares++;
      $display("[ERR] %0t wait %0d expired", $time, k);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk);
    reg_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: x};
    @(posedge clk);
    reg_req <= '0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] x);
    @(posedge clk);
    reg_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge clk);
    reg_req <= '0;
    #1 x = rdata;
  endtask

  // 0 halt, 1 watchdog clear, 2 watchdog overflow
  task automatic pulse(input int k);
    @(posedge clk);
    halt_instr <= (k == 0);
    wclr <= (k == 1);
    ovf <= (k == 2);
    @(posedge clk);
    halt_instr <= 1'b0;
    wclr <= 1'b0;
    ovf <= 1'b0;
    #1;
  endtask

  task automatic pin_reset();
    @(posedge clk);
    pin_n <= 1'b0;
    repeat (5) @(posedge clk);
    pin_n <= 1'b1;
    repeat (4) @(posedge clk);
    wt(0, ST + 20, n);
  endtask

  initial begin
    seed = 20684;
    {miscompares, checks, cyc} = '0;
    {rst_n, halt_instr, wclr, mie, stack_full, ovf, ack_wait, irq_f, irq_e} = '0;
    {wd_slow, lcd_slow, pin_n} = 3'h7;
    reg_req = '0;
    port_a = 8'hff;
    wake_opt = 8'h00;
    repeat (6) @(posedge clk);
    chk1(chip_rst_ff, 1'b1, "reset");
    chk(flags_ff, 16'h0, "power-up flags");
    rst_n <= 1'b1;
    wt(0, ST + 20, n);
    chkn(n, ST, ST + 8, "power-up start-up");
    rd(8'h09, v);
    chk(v, 16'h07, "rate reset");
    rd(8'h1e, v);
    chk(v, 16'h00, "int high reset");
    rd(8'h33, v);
    chk(v, 16'h00, "unmapped");
    repeat (6) begin
      d = $random(seed);
      wr(8'h09, d | 8'h04);
      rd(8'h09, v);
      chk(v, (d | 8'h04) & 8'h17, "rate readback");
      chk1(fast_start, d[4], "start speed");
    end
    $display("test registers done");
    for (int c = 5; c >= 4; c--) begin
      wr(8'h09, 8'(c));
      wt(1, 2 * gap(c) + 10, n);
      wt(1, gap(c) + 10, n);
      chkn(n, gap(c), gap(c), "rtc period");
    end
    rd(8'h1e, v);
    chk(v, 16'h40, "rtc flag");
    chk1(req_ff, 1'b0, "disabled call");
    ack_wait <= 3'($random(seed));
    mie <= 1'b1;
    wr(8'h1e, 8'h44);
    wt(2, 10, n);
    chk(vec_ff, 16'h018, "vector");
    wt(4, 20, n);
    rd(8'h1e, v);
    chk(v, 16'h04, "flag after call");
    stack_full <= 1'b1;
    wt(1, gap(4) + 10, n);
    repeat (3) @(posedge clk);
    #1 chk1(req_ff, 1'b0, "stack full call");
    wr(8'h1e, 8'h40);
    stack_full <= 1'b0;
    $display("test rtc done");
    wake_opt <= ($random(seed) & 8'h7e) | 8'h01;
    pulse(0);
    chk(flags_ff, 16'h1, "halt flags");
    chk1(osc_run_ff, 1'b0, "osc stop");
    chk1(cpu_run_ff, 1'b0, "core stop");
    chk1(wclr_ff, 1'b1, "watchdog clear");
    chk1(lcd_run_ff, 1'b1, "lcd on");
    port_a <= 8'h7f;
    repeat (20) @(posedge clk);
    #1 chk1(cpu_run_ff, 1'b0, "disabled pin");
    @(posedge clk);
    port_a <= 8'h7e;
    wt(3, ST + 20, n);
    chkn(n, ST, ST + 8, "port wake");
    chk1(rint_ff, 1'b0, "next instr");
    port_a <= 8'hff;
    wt(0, 4, n);
    chk(flags_ff, 16'h1, "flags kept");
    pulse(1);
    chk(flags_ff, 16'h0, "clear instr");
    $display("test port wake done");
    for (int s = 0; s < 2; s++) begin
      irq_e <= 5'h1f;
      irq_f <= 5'h01;
      stack_full <= s[0];
      pulse(0);
      repeat (20) @(posedge clk);
      #1 chk1(cpu_run_ff, 1'b0, "stale flag");
      @(posedge clk);
      irq_f <= 5'h03;
      wt(3, ST + 20, n);
      chkn(n, ST, ST + 8, "irq wake");
      chk1(rint_ff, s == 0, "irq response");
      irq_f <= 5'h00;
      wt(0, 4, n);
    end
    stack_full <= 1'b0;
    $display("test irq wake done");
    wr(8'h09, 8'h15);
    pulse(0);
    pulse(2);
    chk1(warm_ff, 1'b1, "warm reset");
    chk(flags_ff, 16'h3, "watchdog wake");
    wt(3, ST + 20, n);
    chk1(rint_ff, 1'b0, "warm resume");
    rd(8'h09, v);
    chk(v, 16'h15, "warm keeps rate");
    pin_reset();
    chk(flags_ff, 16'h3, "pin in run");
    rd(8'h09, v);
    chk(v, 16'h07, "pin rate");
    pulse(1);
    wr(8'h09, 8'h05);
    pulse(2);
    chk1(chip_rst_ff, 1'b1, "run overflow");
    chk(flags_ff, 16'h2, "run overflow flags");
    wt(0, ST + 20, n);
    rd(8'h09, v);
    chk(v, 16'h07, "overflow rate");
    pulse(0);
    pin_reset();
    chk(flags_ff, 16'h1, "pin in sleep");
    $display("test resets done");
    results();
  end
endmodule

`default_nettype wire
